// *** src/wdrsu_pkg.sv ***
// Constants, types and helpers shared by the watchdog / reset source unit and its core end.
// Assumes a single system clock; all bus ends sample synchronously to it.
package wdrsu_pkg;

  // ----------------------------------------------------------------
  // Special function register addresses and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_RESET_CAUSE = 8'hEF;
  localparam logic [7:0] SFR_WDT_CTRL = 8'hFF;
  localparam logic [7:0] RESET_CAUSE_RST = 8'h00;
  localparam int BIT_CNV = 6;
  localparam int BIT_CMP = 5;
  localparam int BIT_SWR = 4;
  localparam int BIT_WDF = 3;
  localparam int BIT_MCD = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_PIN = 0;
  localparam int BIT_WDT_ACTIVE = 4;
  localparam int BIT_INTV_WR_N = 7;

  // ----------------------------------------------------------------
  // Watchdog codes and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] WDT_RESTART = 8'hA5;
  localparam logic [7:0] WDT_DIS_FIRST = 8'hDE;
  localparam logic [7:0] WDT_DIS_SECOND = 8'hAD;
  localparam logic [7:0] WDT_LOCK = 8'hFF;
  localparam int WDT_CNT_W = 21;
  localparam logic [2:0] WDT_INTV_RST = 3'h7;
  localparam logic [2:0] WDT_DIS_WINDOW = 3'h4;
  localparam logic [3:0] RST_MIN_CYC = 4'hC;

  // ----------------------------------------------------------------
  // Core-side bus registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CORE_CMD_OFS = 32'h0000_0000;
  localparam logic [31:0] CORE_STAT_OFS = 32'h0000_0004;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 8;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD} wdrsu_state_t;
  typedef enum logic [1:0] {CS_IDLE, CS_WRITE, CS_READ, CS_CAPTURE} wdrsu_core_state_t;
  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_PIN, CAUSE_MCD, CAUSE_CMP, CAUSE_CNV, CAUSE_WDT, CAUSE_SWR
  } wdrsu_cause_t;

  // Timeout of 4^(3+intv) clocks equals a shift of 6+2*intv
  function automatic logic [WDT_CNT_W-1:0] wdrsu_wdt_limit(input logic [2:0] intv);
    logic [4:0] sh;
    sh = 5'(5'h06 + {1'b0, intv, 1'b0});
    return WDT_CNT_W'(21'h000001 << sh);
  endfunction : wdrsu_wdt_limit

endpackage : wdrsu_pkg

// *** src/wdrsu_sfr_if.sv ***
// Special function register port between the processor core end and the reset unit.
// Both ends share hclk; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface wdrsu_sfr_if;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;

  modport device (
    input sfr_addr,
    input sfr_wr,
    input sfr_rd,
    input sfr_wdata,
    output sfr_rdata
  );

  modport core (
    output sfr_addr,
    output sfr_wr,
    output sfr_rd,
    output sfr_wdata,
    input sfr_rdata
  );
endinterface : wdrsu_sfr_if

// *** src/wdrsu_dev.sv ***
// Watchdog timer and reset source enable / flag logic.
// Assumes hresetn is the power-on reset and all event inputs are synchronous to hclk.
// Function
// - Reset-cause bit 5 enables comparator reset
// - Comparator reset fires when plus below minus
// - Bit 5 reads one only after comparator reset
// - Internal causes leave the reset pin alone
// - Reset-cause bit 6 enables convert-start reset
// - Convert-start reset is active-low level
// - Bit 6 reads one only after convert-start reset
// - Watchdog overflow resets, flagged in bit 3
// - After reset watchdog runs, interval 111b
// - Watchdog uses 21-bit counter on system clock
// - Code A5 enables and restarts watchdog
// - DE then AD within 4 clocks disables
// - Code FF locks out disable until reset
// - Timeout is 4^(3+interval) clock periods
// - Interval written only when bit 7 clear
// - Read gives interval and active bit 4
// - Bit 4 write forces internal reset, flagged
// - Bit 2 enables missing clock reset, flags it
// - Bit 1 selects supply monitor when pin enabled
// - Bit 1 flags power-on or monitor reset
// - Bit 0 write forces power-on, pin low
// - Software enables sources only after setup
// - Other causes clear the power-on flag
`timescale 1ns/1ps
module wdrsu_dev (
  input wire logic hclk,
  input wire logic hresetn,
  wdrsu_sfr_if.device sfr,
  input wire logic cmp_plus_above,
  input wire logic convert_start_input,
  input wire logic supply_monitor_enable_pin,
  input wire logic supply_low,
  input wire logic missing_clock_timeout,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic sys_reset
);

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  wdrsu_pkg::wdrsu_state_t state_q;
  wdrsu_pkg::wdrsu_cause_t cause_d;
  logic [7:0] flags_q;
  logic cmp_en_q, cnv_en_q, mcd_en_q, mon_sel_q;
  logic wdt_en_q, wdt_lock_q;
  logic [2:0] wdt_intv_q;
  logic [2:0] dis_win_q;
  logic [wdrsu_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
  logic [3:0] hold_q;
  logic pin_drive_q;
  logic [7:0] rdata_q;

  wire running = (state_q == wdrsu_pkg::ST_RUN);
  // Writes landing while the unit is held in reset are dropped
  wire wr_rsrc = sfr.sfr_wr & running & (sfr.sfr_addr == wdrsu_pkg::SFR_RESET_CAUSE);
  wire wr_wdt = sfr.sfr_wr & running & (sfr.sfr_addr == wdrsu_pkg::SFR_WDT_CTRL);
  wire [7:0] wd = sfr.sfr_wdata;
  wire wr_restart = wr_wdt & (wd == wdrsu_pkg::WDT_RESTART);
  wire wr_dis1 = wr_wdt & (wd == wdrsu_pkg::WDT_DIS_FIRST) & ~wdt_lock_q;
  wire wr_dis2 = wr_wdt & (wd == wdrsu_pkg::WDT_DIS_SECOND) & ~wdt_lock_q & (dis_win_q != 3'h0);
  wire wr_lock = wr_wdt & (wd == wdrsu_pkg::WDT_LOCK);
  wire wr_intv = wr_wdt & ~wd[wdrsu_pkg::BIT_INTV_WR_N];

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  wire [wdrsu_pkg::WDT_CNT_W-1:0] wdt_last =
    wdrsu_pkg::WDT_CNT_W'(wdrsu_pkg::wdrsu_wdt_limit(wdt_intv_q) - 21'h000001);
  wire cmp_trip = cmp_en_q & ~cmp_plus_above;
  wire cnv_trip = cnv_en_q & ~convert_start_input;
  wire mon_trip = supply_monitor_enable_pin & mon_sel_q & supply_low;
  wire mcd_trip = mcd_en_q & missing_clock_timeout;
  // Our own pin drive must not read back as an external pin reset
  wire pin_trip = ~rst_pin_in & ~pin_drive_q;
  wire wdt_trip = wdt_en_q & (wdt_cnt_q == wdt_last);
  wire swr_trip = wr_rsrc & wd[wdrsu_pkg::BIT_SWR];
  wire por_force = wr_rsrc & wd[wdrsu_pkg::BIT_PIN];
  wire level_hold = cmp_trip | cnv_trip | mon_trip | pin_trip;
  wire any_trip = level_hold | mcd_trip | wdt_trip | swr_trip | por_force;
  wire release_now = ~running & (hold_q == 4'h0) & ~level_hold;
  // Only power-on class resets drive the pin
  wire drive_pin = mon_trip | por_force;

  always_comb begin
    if (mon_trip | por_force) begin
      cause_d = wdrsu_pkg::CAUSE_POR;
    end else if (pin_trip) begin
      cause_d = wdrsu_pkg::CAUSE_PIN;
    end else if (mcd_trip) begin
      cause_d = wdrsu_pkg::CAUSE_MCD;
    end else if (cmp_trip) begin
      cause_d = wdrsu_pkg::CAUSE_CMP;
    end else if (cnv_trip) begin
      cause_d = wdrsu_pkg::CAUSE_CNV;
    end else if (wdt_trip) begin
      cause_d = wdrsu_pkg::CAUSE_WDT;
    end else begin
      cause_d = wdrsu_pkg::CAUSE_SWR;
    end
  end

  // One-hot flag image; every cause clears all other flags
  logic [7:0] flags_d;
  always_comb begin
    flags_d = wdrsu_pkg::RESET_CAUSE_RST;
    unique case (cause_d)
      wdrsu_pkg::CAUSE_POR: flags_d[wdrsu_pkg::BIT_POR] = 1'b1;
      wdrsu_pkg::CAUSE_PIN: flags_d[wdrsu_pkg::BIT_PIN] = 1'b1;
      wdrsu_pkg::CAUSE_MCD: flags_d[wdrsu_pkg::BIT_MCD] = 1'b1;
      wdrsu_pkg::CAUSE_CMP: flags_d[wdrsu_pkg::BIT_CMP] = 1'b1;
      wdrsu_pkg::CAUSE_CNV: flags_d[wdrsu_pkg::BIT_CNV] = 1'b1;
      wdrsu_pkg::CAUSE_WDT: flags_d[wdrsu_pkg::BIT_WDF] = 1'b1;
      wdrsu_pkg::CAUSE_SWR: flags_d[wdrsu_pkg::BIT_SWR] = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Reset sequencer and flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= wdrsu_pkg::ST_RUN;
      hold_q <= 4'h0;
      pin_drive_q <= 1'b0;
      flags_q <= 8'h02;
    end else if (running & any_trip) begin
      state_q <= wdrsu_pkg::ST_HOLD;
      hold_q <= wdrsu_pkg::RST_MIN_CYC;
      pin_drive_q <= drive_pin;
      flags_q <= flags_d;
    end else if (release_now) begin
      state_q <= wdrsu_pkg::ST_RUN;
      pin_drive_q <= 1'b0;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Source enables; cleared by every reset except monitor select
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_en_q <= 1'b0;
      cnv_en_q <= 1'b0;
      mcd_en_q <= 1'b0;
      mon_sel_q <= 1'b1;
    end else if (release_now) begin
      cmp_en_q <= 1'b0;
      cnv_en_q <= 1'b0;
      mcd_en_q <= 1'b0;
      mon_sel_q <= 1'b1;
    end else if (wr_rsrc) begin
      cmp_en_q <= wd[wdrsu_pkg::BIT_CMP];
      cnv_en_q <= wd[wdrsu_pkg::BIT_CNV];
      mcd_en_q <= wd[wdrsu_pkg::BIT_MCD];
      mon_sel_q <= wd[wdrsu_pkg::BIT_POR];
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_en_q <= 1'b1;
      wdt_lock_q <= 1'b0;
      wdt_intv_q <= wdrsu_pkg::WDT_INTV_RST;
    end else if (!running) begin
      wdt_en_q <= 1'b1;
      wdt_lock_q <= 1'b0;
      wdt_intv_q <= wdrsu_pkg::WDT_INTV_RST;
    end else begin
      if (wr_restart) begin
        wdt_en_q <= 1'b1;
      end else if (wr_dis2) begin
        wdt_en_q <= 1'b0;
      end
      if (wr_lock) begin
        wdt_lock_q <= 1'b1;
      end
      if (wr_intv) begin
        wdt_intv_q <= wd[2:0];
      end
    end
  end

  // A pending first disable code expires after four clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dis_win_q <= 3'h0;
    end else if (!running | wr_dis2) begin
      dis_win_q <= 3'h0;
    end else if (wr_dis1) begin
      dis_win_q <= wdrsu_pkg::WDT_DIS_WINDOW;
    end else if (dis_win_q != 3'h0) begin
      dis_win_q <= dis_win_q - 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_q <= '0;
    end else if (!running | wr_restart | ~wdt_en_q) begin
      wdt_cnt_q <= '0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 21'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  wire [7:0] wdt_view = {3'h0, wdt_en_q, 1'b0, wdt_intv_q};
  wire [7:0] rd_mux = (sfr.sfr_addr == wdrsu_pkg::SFR_RESET_CAUSE) ? flags_q :
                      (sfr.sfr_addr == wdrsu_pkg::SFR_WDT_CTRL) ? wdt_view : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 8'h00;
    end else if (sfr.sfr_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr.sfr_rdata = rdata_q;
  assign sys_reset = ~running;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = pin_drive_q;

endmodule : wdrsu_dev

// *** src/wdrsu_core.sv ***
// Processor core end: AHB-Lite slave whose command register launches one register access.
// Assumes the one AHB master on hclk; zero wait states, always OKAY.
`timescale 1ns/1ps
module wdrsu_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  wdrsu_sfr_if.core sfr
);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  wdrsu_pkg::wdrsu_core_state_t state_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [7:0] addr_q, wdata_q, rdata_q;
  logic do_write_q;

  // Only whole-word transfers are issued; hsize is not checked
  wire ap_take = hsel & hready & htrans[1];
  wire busy = (state_q != wdrsu_pkg::CS_IDLE);
  wire [31:0] stat_view = {23'h000000, busy, rdata_q};
  wire [31:0] rd_mux = (haddr == wdrsu_pkg::CORE_STAT_OFS) ? stat_view : 32'h0000_0000;
  // Commands arriving while busy are dropped; software polls busy first
  wire cmd_take = wr_pend_q & (wr_addr_q == wdrsu_pkg::CORE_CMD_OFS) & ~busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= ap_take & hwrite;
      if (ap_take) begin
        wr_addr_q <= haddr;
      end
      if (ap_take & ~hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= wdrsu_pkg::CS_IDLE;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      do_write_q <= 1'b0;
    end else begin
      unique case (state_q)
        wdrsu_pkg::CS_IDLE: begin
          if (cmd_take) begin
            addr_q <= hwdata[wdrsu_pkg::CMD_ADDR_LSB +: 8];
            wdata_q <= hwdata[wdrsu_pkg::CMD_DATA_LSB +: 8];
            do_write_q <= hwdata[wdrsu_pkg::CMD_WRITE_BIT];
            state_q <= hwdata[wdrsu_pkg::CMD_WRITE_BIT] ? wdrsu_pkg::CS_WRITE
                                                        : wdrsu_pkg::CS_READ;
          end
        end
        wdrsu_pkg::CS_WRITE: state_q <= wdrsu_pkg::CS_IDLE;
        wdrsu_pkg::CS_READ: state_q <= wdrsu_pkg::CS_CAPTURE;
        wdrsu_pkg::CS_CAPTURE: state_q <= wdrsu_pkg::CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 8'h00;
    end else if (state_q == wdrsu_pkg::CS_CAPTURE) begin
      rdata_q <= sfr.sfr_rdata;
    end
  end

  assign sfr.sfr_addr = addr_q;
  assign sfr.sfr_wdata = wdata_q;
  assign sfr.sfr_wr = (state_q == wdrsu_pkg::CS_WRITE) & do_write_q;
  assign sfr.sfr_rd = (state_q == wdrsu_pkg::CS_READ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

endmodule : wdrsu_core

// *** test/wdrsu_chk.sv ***
// Assertions on the register link and reset outputs of the reset unit.
// Sits beside the link interface; one clock, hresetn async low.
`timescale 1ns/1ps
module wdrsu_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sys_reset,
  input wire logic rst_pin_oe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------
  // Reference watchdog
  // ----------
  logic [2:0] intv_q;
  logic act_q;
  logic lock_q;
  logic [2:0] age_q;
  logic [20:0] cnt_q;
  wire logic wr_w = sfr_wr && !sys_reset && sfr_addr == 8'hFF;
  wire logic rd_w = sfr_rd && !sys_reset;
  wire logic a5_w = wr_w && sfr_wdata == 8'hA5;
  wire logic de_w = wr_w && sfr_wdata == 8'hDE && !lock_q;
  // Second code counts only 1..4 edges after the first
  wire logic ad_w = wr_w && sfr_wdata == 8'hAD && !lock_q && age_q != 3'h0 && age_q < 3'h5;
  wire logic swf_w = sfr_wr && !sys_reset && sfr_addr == 8'hEF && sfr_wdata[4];
  wire logic pinf_w = sfr_wr && !sys_reset && sfr_addr == 8'hEF && sfr_wdata[0];
  wire logic [20:0] lim_w = 21'h000001 << ({1'b0, intv_q, 1'b0} + 5'h06);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {intv_q, act_q, lock_q, age_q, cnt_q} <= {5'h1E, 24'h000000};
    end else if (sys_reset) begin
      {intv_q, act_q, lock_q, age_q, cnt_q} <= {5'h1E, 24'h000000};
    end else begin
      intv_q <= (wr_w && !sfr_wdata[7]) ? sfr_wdata[2:0] : intv_q;
      act_q <= a5_w | (act_q & !ad_w);
      lock_q <= lock_q | (wr_w && sfr_wdata == 8'hFF);
      age_q <= de_w ? 3'h1 : (age_q != 3'h0 && age_q < 3'h5) ? age_q + 3'h1 : 3'h0;
      cnt_q <= (a5_w || !act_q) ? 21'h000000 : cnt_q + 21'h000001;
    end
  end

  sequence rd_wdt_s;
    rd_w && sfr_addr == 8'hFF;
  endsequence
  sequence ovf_s;
    act_q && cnt_q == lim_w - 21'h000001;
  endsequence
  sequence quiet_rst_s;
    ##[1:4] (sys_reset && !rst_pin_oe);
  endsequence

  intv_read_a: assert property (rd_wdt_s |=> sfr_rdata[2:0] == $past(intv_q))
    else $error("interval read wrong");
  act_read_a: assert property (rd_wdt_s |=> sfr_rdata[4] == $past(act_q))
    else $error("active bit read wrong");
  wdt_zero_a: assert property (rd_wdt_s |=> {sfr_rdata[7:5], sfr_rdata[3]} == 4'h0)
    else $error("unused watchdog bits set");
  one_flag_a: assert property (rd_w && sfr_addr == 8'hEF |=> $onehot0(sfr_rdata))
    else $error("several reset flags set");
  wdt_ovf_a: assert property (ovf_s |-> ##[0:3] (sys_reset && !rst_pin_oe))
    else $error("watchdog overflow missed");
  sw_force_a: assert property (swf_w && !sfr_wdata[0] |-> quiet_rst_s)
    else $error("software reset missed");
  pin_force_a: assert property (pinf_w |-> ##[1:4] (sys_reset && rst_pin_oe))
    else $error("forced reset without pin");
  rst_hold_a: assert property ($rose(sys_reset) |-> sys_reset[*8])
    else $error("reset too short");
endmodule : wdrsu_chk

// *** test/testbench.sv ***
// Bench joining both ends of the register link, driven over AHB-Lite.
// Assumes a zero-wait core slave and reset sources that release on demand.
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic cmp_plus_above = 1'b1;
  logic convert_start_input = 1'b1;
  logic supply_low = 1'b0;
  logic missing_clock_timeout = 1'b0;
  logic ext_rst_n = 1'b1;
  logic mon_pin = 1'b1;
  logic [31:0] bus_q;
  int err_total = 0;
  int cmp_count = 0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic rst_pin_out;
  wire logic rst_pin_oe;
  wire logic sys_reset;
  // Open-drain reset pin: the device wins while it drives
  wire logic pin_w = rst_pin_oe ? rst_pin_out : ext_rst_n;

  wdrsu_sfr_if wdrsu_sfr_if_inst ();
  wdrsu_core wdrsu_core_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .sfr(wdrsu_sfr_if_inst));
  wdrsu_dev wdrsu_dev_inst (.hclk, .hresetn, .sfr(wdrsu_sfr_if_inst), .cmp_plus_above,
    .convert_start_input, .supply_monitor_enable_pin(mon_pin), .supply_low,
    .missing_clock_timeout, .rst_pin_in(pin_w), .rst_pin_out, .rst_pin_oe, .sys_reset);
  wdrsu_chk wdrsu_chk_inst (.hclk, .hresetn, .sfr_addr(wdrsu_sfr_if_inst.sfr_addr),
    .sfr_wr(wdrsu_sfr_if_inst.sfr_wr), .sfr_rd(wdrsu_sfr_if_inst.sfr_rd),
    .sfr_wdata(wdrsu_sfr_if_inst.sfr_wdata), .sfr_rdata(wdrsu_sfr_if_inst.sfr_rdata),
    .sys_reset, .rst_pin_oe);

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input logic hit);
    if (hit) begin
      err_total++;
      end_of_test();
    end
  endtask : give_up

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    give_up(n >= 50);
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : ahb

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, 32'h0000_0000, {15'h0000, 1'b1, d, a}, bus_q);
  endtask : sw

  // Poll status until the launched read has landed
  task automatic srd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    ahb(1'b1, 32'h0000_0000, {24'h000000, a}, bus_q);
    n = 0;
    bus_q = 32'h0000_0100;
    while (bus_q[8] !== 1'b0 && n < 20) begin
      n++;
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000, bus_q);
    end
    give_up(n >= 20);
    chk($sformatf("sfr %h", a), exp, bus_q[7:0]);
  endtask : srd

  task automatic quiet();
    logic s;
    s = 1'b0;
    repeat (20) begin
      @(posedge hclk);
      s = s | sys_reset;
    end
    chk("reset seen", 8'h00, {7'h00, s});
  endtask : quiet

  // Sources are released once reset is seen, so the unit can leave it
  task automatic wait_rst(input logic [7:0] flags, input logic pin);
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    while (sys_reset !== 1'b1 && n < 100) begin
      n++;
      @(posedge hclk);
    end
    give_up(n >= 100);
    @(posedge hclk);
    cmp_plus_above <= 1'b1;
    convert_start_input <= 1'b1;
    supply_low <= 1'b0;
    missing_clock_timeout <= 1'b0;
    ext_rst_n <= 1'b1;
    n = 0;
    // Count the pin as driven only if it really reads low while enabled
    while (sys_reset === 1'b1 && n < 400) begin
      seen = seen | (rst_pin_oe & ~pin_w);
      n++;
      @(posedge hclk);
    end
    give_up(n >= 400);
    chk("pin driven", {7'h00, pin}, {7'h00, seen});
    srd(8'hEF, flags);
  endtask : wait_rst

  initial begin
    forever begin
      #2 hclk = ~hclk;
    end
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    srd(8'hEF, 8'h02);
    srd(8'hFF, 8'h17);
    srd(8'h10, 8'h00);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, bus_q);
    chk("unmapped word", 8'h00, {7'h00, bus_q !== 32'h0000_0000});
    chk("bus response", 8'h00, {7'h00, hresp});
    $display("test reset values done");
    sw(8'hFF, 8'h03);
    srd(8'hFF, 8'h13);
    sw(8'hFF, 8'h85);
    srd(8'hFF, 8'h13);
    sw(8'hFF, 8'hDE);
    sw(8'hFF, 8'hAD);
    srd(8'hFF, 8'h03);
    sw(8'hFF, 8'hA5);
    srd(8'hFF, 8'h13);
    sw(8'hFF, 8'hDE);
    repeat (6) @(posedge hclk);
    sw(8'hFF, 8'hAD);
    srd(8'hFF, 8'h13);
    sw(8'hFF, 8'hDE);
    sw(8'hFF, 8'hAD);
    sw(8'hFF, 8'hFF);
    srd(8'hFF, 8'h03);
    sw(8'hFF, 8'hA5);
    sw(8'hFF, 8'hDE);
    sw(8'hFF, 8'hAD);
    srd(8'hFF, 8'h13);
    $display("test watchdog control done");
    sw(8'hEF, 8'h10);
    wait_rst(8'h10, 1'b0);
    srd(8'hFF, 8'h17);
    sw(8'hFF, 8'hDE);
    sw(8'hFF, 8'hAD);
    sw(8'hFF, 8'h00);
    srd(8'hFF, 8'h00);
    sw(8'hFF, 8'hA5);
    quiet();
    wait_rst(8'h08, 1'b0);
    $display("test software and watchdog reset done");
    for (int i = 0; i < 3; i++) begin
      cmp_plus_above <= (i != 0);
      convert_start_input <= (i != 1);
      missing_clock_timeout <= (i == 2);
      quiet();
      sw(8'hEF, i == 0 ? 8'h20 : i == 1 ? 8'h40 : 8'h04);
      wait_rst(i == 0 ? 8'h20 : i == 1 ? 8'h40 : 8'h04, 1'b0);
    end
    sw(8'hEF, 8'h01);
    wait_rst(8'h02, 1'b1);
    ext_rst_n <= 1'b0;
    wait_rst(8'h01, 1'b0);
    supply_low <= 1'b1;
    wait_rst(8'h02, 1'b1);
    sw(8'hEF, 8'h00);
    // Let the deselect land before the supply drops, or the old select still trips
    repeat (2) @(posedge hclk);
    supply_low <= 1'b1;
    quiet();
    mon_pin <= 1'b0;
    sw(8'hEF, 8'h02);
    quiet();
    supply_low <= 1'b0;
    mon_pin <= 1'b1;
    $display("test reset sources done");
    end_of_test();
  end
endmodule : testbench
